// ==== verilog/scsb_pkg.sv ====
// Package: shared constants and types for the serial channel service block
`default_nettype none
package scsb_pkg;
   // Priority order: A rx, A tx, A ext, B rx, B tx, B ext
   localparam int SCSB_NUM_CH = 2;
   localparam int SCSB_DMA_PULSE_CYC = 3;
   localparam int SCSB_FIFO_DEPTH = 3;
   localparam logic [7:0] SCSB_TC_RESET = 8'h01;
   localparam logic [7:0] SCSB_VECT_RESET = 8'h0F;
   // Host port register offsets (channel registers: base + ch*CH_STRIDE; VECT and ACK shared)
   localparam logic [4:0] SCSB_REG_CTRL = 5'h00;
   localparam logic [4:0] SCSB_REG_TC = 5'h01;
   localparam logic [4:0] SCSB_REG_BRG = 5'h02;
   localparam logic [4:0] SCSB_REG_CMD = 5'h03;
   localparam logic [4:0] SCSB_REG_STAT0 = 5'h04;
   localparam logic [4:0] SCSB_REG_STAT1 = 5'h05;
   localparam logic [4:0] SCSB_REG_DATA = 5'h06;
   localparam logic [4:0] SCSB_REG_VECT = 5'h10;
   localparam logic [4:0] SCSB_REG_ACK = 5'h11;
   localparam logic [4:0] SCSB_CH_STRIDE = 5'h08;
   // Interrupt control fields
   localparam int SCSB_IC_TXIE = 0;
   localparam int SCSB_IC_EXTIE = 1;
   localparam int SCSB_IC_RXM_LO = 2;
   localparam int SCSB_IC_SAV = 4;
   localparam int SCSB_IC_PARIE = 5;
   localparam int SCSB_IC_TXDMA = 6;
   localparam int SCSB_IC_RXDMA = 7;
   localparam int SCSB_IC_LOOP = 8;
   // Baud control fields
   localparam int SCSB_BC_EN = 0;
   localparam int SCSB_BC_DIV64 = 1;
   localparam int SCSB_BC_TXCK = 2;
   localparam int SCSB_BC_RXCK = 3;
   localparam int SCSB_PRE4 = 4;
   localparam int SCSB_PRE64 = 64;
   // Commands
   localparam logic [2:0] SCSB_CMD_NONE = 3'h0;
   localparam logic [2:0] SCSB_CMD_RST_EXT = 3'h2;
   localparam logic [2:0] SCSB_CMD_NEXT_RX = 3'h4;
   localparam logic [2:0] SCSB_CMD_RST_TX = 3'h5;
   localparam logic [2:0] SCSB_CMD_ERR_RST = 3'h6;
   typedef enum logic [1:0] {SCSB_RX_OFF, SCSB_RX_FIRST, SCSB_RX_ALL_PAR, SCSB_RX_ALL} scsb_rxmode_t;
endpackage
`default_nettype wire

// ==== verilog/scsb_link_if.sv ====
// Interface: bus and pin signals between host service logic and device
`timescale 1ns/1ps
`default_nettype none
interface scsb_link_if;
   import scsb_pkg::*;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic intReq_n;
   logic [1:0] txDmaRequest_n;
   logic [1:0] rxDmaRequest_n;
   modport device (input addr, wdata, wr, rd,
      output rdata, intReq_n, txDmaRequest_n, rxDmaRequest_n);
   modport host (output addr, wdata, wr, rd,
      input rdata, intReq_n, txDmaRequest_n, rxDmaRequest_n);
endinterface
`default_nettype wire

// ==== verilog/scsb_host.sv ====
// Host end: turns user register requests into bus cycles, reports requests
`timescale 1ns/1ps
`default_nettype none
module scsb_host
   import scsb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   scsb_link_if.host link,
   input wire logic [4:0] userAddr,
   input wire logic [15:0] userWdata,
   input wire logic userWr,
   input wire logic userRd,
   output logic [15:0] userRdata,
   output logic userRdValid,
   output logic intPending,
   output logic [1:0] txDmaSeen,
   output logic [1:0] rxDmaSeen
);
   logic rdPend_reg;
   // Polled operation needs all interrupt modes off; user programs that
   // Time constant writes should follow a baud disable; user sequences that
   assign link.addr = userAddr;
   assign link.wdata = userWdata;
   assign link.wr = userWr & ~userRd;
   assign link.rd = userRd;
   assign intPending = ~link.intReq_n;
   assign txDmaSeen = ~link.txDmaRequest_n;
   assign rxDmaSeen = ~link.rxDmaRequest_n;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdPend_reg <= 1'b0;
         userRdata <= 16'h0000;
      end else begin
         rdPend_reg <= userRd;
         if (rdPend_reg) begin
            userRdata <= link.rdata;
         end
      end
   end
   assign userRdValid = rdPend_reg;
endmodule // scsb_host
`default_nettype wire

// ==== verilog/scsb_device.sv ====
// Device end: status, vectored interrupts, DMA strobes, loopback, baud gens
// What this block does
// - Polled status: D0 rx ready, D2 tx empty
// - Status-affects-vector picks one of eight routines
// - Vector modify bit in either channel acts globally
// - Priority A over B; rx, tx, ext
// - Tx interrupt when loaded buffer empties
// - First-char mode: first char, then specials only
// - Next-rx-char command re-arms first-char interrupt
// - Special condition in first-char mode holds FIFO until error reset
// - All-char mode: any char or special
// - Specials need char mode; alter rx vector
// - Parity and overrun latched until error reset
// - Ext event on pins, underrun, break; latch three
// - Ext detection frozen until reset-ext command
// - Break interrupts at start and end
// - Low-active DMA strobes, three clocks each
// - First-char special: interrupt, no rx DMA
// - Loop mode feeds tx data and clock back
// - 8-bit constant, down counter, toggle output
// - Prescale divide by four or sixty-four
// - Baud output routable to tx/rx clock pins
// - Reset: baud off, divide four, pins inputs
// - Software disables baud before constant writes
// - Three-byte receive FIFO with error FIFO
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module scsb_device
   import scsb_pkg::*;
#(
   parameter int DEPTH = SCSB_FIFO_DEPTH
)(
   input wire logic ref_clk,
   input wire logic rst,
   scsb_link_if.device link,
   // Per channel line side, bit index = channel (0 = A)
   input wire logic [1:0] rxCharStb,
   input wire logic [15:0] rxCharData,
   input wire logic [1:0] rxParErr,
   input wire logic [1:0] rxFrameErr,
   input wire logic [1:0] rxEndFrame,
   input wire logic [1:0] txLoadStb,
   input wire logic [1:0] txUnderrun,
   input wire logic [1:0] breakDet,
   input wire logic [1:0] ctsPin,
   input wire logic [1:0] dcdPin,
   input wire logic [1:0] syncPin,
   input wire logic [1:0] txDataLine,
   input wire logic [1:0] rxDataPin,
   input wire logic [1:0] txClockPinIn,
   input wire logic [1:0] rxClockPinIn,
   output logic [1:0] txClockPinOut,
   output logic [1:0] txClockPinOe_n,
   output logic [1:0] rxClockPinOut,
   output logic [1:0] rxClockPinOe_n,
   output logic [1:0] rxDataInternal,
   output logic [1:0] rxClockInternal
);
   logic [7:0] vect_reg;
   logic [1:0] ackSeq;
   logic [5:0] pendAll;
   logic [8:0] ctrl [SCSB_NUM_CH];
   logic [15:0] chRd [SCSB_NUM_CH];
   logic globalSav;
   logic [2:0] winner;
   logic anyPend;
   assign globalSav = ctrl[0][SCSB_IC_SAV] | ctrl[1][SCSB_IC_SAV];
   // ******************************************************
   // Per-channel logic
   // ******************************************************
   genvar c;
   generate
      for (c = 0; c < SCSB_NUM_CH; c++) begin : g_ch
         logic [4:0] base;
         logic selCtrl, selTc, selBrg, selCmd, selData, ack;
         logic [2:0] cmd;
         logic [8:0] ctrl_reg;
         logic [7:0] tc_reg, cnt_reg;
         logic [3:0] brg_reg;
         logic [5:0] pre_reg;
         logic baud_reg;
         logic [7:0] fData [DEPTH];
         logic [1:0] fErr [DEPTH];
         logic [1:0] fCount_reg;
         logic fPop, fPush, fFull;
         logic parLatch_reg, ovrLatch_reg;
         logic firstArmed_reg, holdSpecial_reg;
         logic txLoaded_reg, txEmpty_reg, txPend_reg;
         logic rxPend_reg, specPend_reg;
         logic [2:0] extSync1, extSync2, extSync3, extState_reg;
         logic extLock_reg, extPend_reg, breakSeen_reg;
         logic [1:0] txDmaCnt_reg, rxDmaCnt_reg;
         logic special, rxMode1, rxAll, preTick;
         logic [2:0] extNow;
         assign base = 5'(c) * SCSB_CH_STRIDE;
         assign selCtrl = link.addr == base + SCSB_REG_CTRL;
         assign selTc = link.addr == base + SCSB_REG_TC;
         assign selBrg = link.addr == base + SCSB_REG_BRG;
         assign selCmd = link.wr && link.addr == base + SCSB_REG_CMD;
         assign selData = link.rd && link.addr == base + SCSB_REG_DATA;
         assign cmd = selCmd ? link.wdata[2:0] : SCSB_CMD_NONE;
         assign ack = link.rd && link.addr == SCSB_REG_ACK && anyPend && winner[2] == 1'(c);
         assign ctrl[c] = ctrl_reg;
         assign rxMode1 = ctrl_reg[3:2] == SCSB_RX_FIRST;
         assign rxAll = ctrl_reg[3] == 1'b1;
         assign fFull = fCount_reg == 2'(DEPTH);
         assign fPush = rxCharStb[c] & ~fFull;
         assign fPop = selData & fCount_reg != 2'd0 & ~holdSpecial_reg;
         // Special: overrun, framing, end of frame; parity only in its mode
         assign special = rxCharStb[c] & (fFull | rxFrameErr[c] | rxEndFrame[c]
            | (rxParErr[c] & ctrl_reg[3:2] == SCSB_RX_ALL_PAR));
         assign extNow = {breakDet[c], dcdPin[c], ctsPin[c]};
         // Toggle flop halves the rate, so each half period is half the prescale
         assign preTick = pre_reg == 6'((brg_reg[SCSB_BC_DIV64] ? SCSB_PRE64 : SCSB_PRE4) / 2 - 1);
         assign chRd[c] = {fCount_reg != 2'd0 ? fData[0] : 8'hFF, 1'b0,
            extState_reg, syncPin[c], txEmpty_reg, 1'b0, fCount_reg != 2'd0};
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               ctrl_reg <= '0;
               tc_reg <= SCSB_TC_RESET;
               brg_reg <= '0;
               cnt_reg <= SCSB_TC_RESET;
               pre_reg <= '0;
               baud_reg <= 1'b0;
            end else begin
               if (link.wr && selCtrl) ctrl_reg <= link.wdata[8:0];
               if (link.wr && selTc) tc_reg <= link.wdata[7:0];
               if (link.wr && selBrg) brg_reg <= link.wdata[3:0];
               if (!brg_reg[SCSB_BC_EN]) begin
                  pre_reg <= '0;
                  cnt_reg <= tc_reg;
               end else begin
                  pre_reg <= preTick ? 6'd0 : pre_reg + 6'd1;
                  if (preTick) begin
                     // 00H counts 256 by wrapping
                     cnt_reg <= cnt_reg == 8'd1 ? tc_reg : cnt_reg - 8'd1;
                     if (cnt_reg == 8'd1) baud_reg <= ~baud_reg;
                  end
               end
            end
         end
         // Baud output on clock pins; undriven pins stay inputs
         assign txClockPinOut[c] = baud_reg;
         assign rxClockPinOut[c] = baud_reg;
         assign txClockPinOe_n[c] = ~(brg_reg[SCSB_BC_EN] & brg_reg[SCSB_BC_TXCK]);
         assign rxClockPinOe_n[c] = ~(brg_reg[SCSB_BC_EN] & brg_reg[SCSB_BC_RXCK]);
         // Loop mode isolates the receive pins
         assign rxDataInternal[c] = ctrl_reg[SCSB_IC_LOOP] ? txDataLine[c] : rxDataPin[c];
         assign rxClockInternal[c] = ctrl_reg[SCSB_IC_LOOP] ? txClockPinIn[c] : rxClockPinIn[c];
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               fCount_reg <= '0;
               for (int i = 0; i < DEPTH; i++) begin
                  fData[i] <= '0;
                  fErr[i] <= '0;
               end
            end else begin
               // Data and error FIFOs shift together
               if (fPop) begin
                  for (int i = 0; i < DEPTH - 1; i++) begin
                     fData[i] <= fData[i+1];
                     fErr[i] <= fErr[i+1];
                  end
               end
               if (fPush) begin
                  fData[32'(fCount_reg) - (fPop ? 1 : 0)] <= rxCharData[c*8 +: 8];
                  fErr[32'(fCount_reg) - (fPop ? 1 : 0)] <= {rxFrameErr[c], rxParErr[c]};
               end
               fCount_reg <= fCount_reg + 2'(fPush) - 2'(fPop);
            end
         end
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               parLatch_reg <= 1'b0;
               ovrLatch_reg <= 1'b0;
               firstArmed_reg <= 1'b1;
               holdSpecial_reg <= 1'b0;
               specPend_reg <= 1'b0;
               rxPend_reg <= 1'b0;
               txLoaded_reg <= 1'b0;
               txEmpty_reg <= 1'b1;
               txPend_reg <= 1'b0;
            end else begin
               // Errors stick until reset; a new error wins
               parLatch_reg <= (parLatch_reg & cmd != SCSB_CMD_ERR_RST) | (rxCharStb[c] & rxParErr[c]);
               ovrLatch_reg <= (ovrLatch_reg & cmd != SCSB_CMD_ERR_RST) | (rxCharStb[c] & fFull);
               if (link.wr && selCtrl && link.wdata[3:2] == SCSB_RX_FIRST) firstArmed_reg <= 1'b1;
               else if (cmd == SCSB_CMD_NEXT_RX) firstArmed_reg <= 1'b1;
               else if (fPush && rxMode1) firstArmed_reg <= 1'b0;
               holdSpecial_reg <= (holdSpecial_reg & cmd != SCSB_CMD_ERR_RST) | (special & rxMode1);
               specPend_reg <= (specPend_reg & ~(ack & winner[1:0] == 2'd0) & cmd != SCSB_CMD_ERR_RST)
                  | (special & ctrl_reg[3:2] != SCSB_RX_OFF);
               rxPend_reg <= (rxAll & (fCount_reg != 2'd0 | fPush)) | (rxMode1 & fPush & firstArmed_reg)
                  | (rxPend_reg & rxMode1 & ~(ack & winner[1:0] == 2'd0));
               txEmpty_reg <= (txEmpty_reg & ~txLoadStb[c]) | (txLoaded_reg & ~txLoadStb[c]);
               txLoaded_reg <= txLoadStb[c];
               // Empty event only after a load
               txPend_reg <= (txPend_reg & ~(ack & winner[1:0] == 2'd1) & cmd != SCSB_CMD_RST_TX
                  & ~txLoadStb[c])
                  | (txLoaded_reg & ctrl_reg[SCSB_IC_TXIE]);
            end
         end
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               extSync1 <= '0;
               extSync2 <= '0;
               extSync3 <= '0;
               extState_reg <= '0;
               extLock_reg <= 1'b0;
               extPend_reg <= 1'b0;
               breakSeen_reg <= 1'b0;
            end else begin
               extSync1 <= extNow;
               extSync2 <= extSync1;
               extSync3 <= extSync2;
               breakSeen_reg <= extSync3[2];
               if (cmd == SCSB_CMD_RST_EXT) begin
                  extLock_reg <= 1'b0;
                  extPend_reg <= 1'b0;
                  extState_reg <= extSync3;
               end else if (!extLock_reg && ((extSync2 == extSync3 && extSync3 != extState_reg)
                  || txUnderrun[c])) begin
                  // Break edges both ways count
                  extLock_reg <= 1'b1;
                  extPend_reg <= ctrl_reg[SCSB_IC_EXTIE];
                  extState_reg <= extSync3;
               end else if (ack && winner[1:0] == 2'd2) begin
                  extPend_reg <= 1'b0;
               end
            end
         end
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               txDmaCnt_reg <= '0;
               rxDmaCnt_reg <= '0;
            end else begin
               // Three-clock low strobes
               if (txLoaded_reg && ctrl_reg[SCSB_IC_TXDMA]) txDmaCnt_reg <= 2'(SCSB_DMA_PULSE_CYC);
               else if (txDmaCnt_reg != 2'd0) txDmaCnt_reg <= txDmaCnt_reg - 2'd1;
               if (fPush && ctrl_reg[SCSB_IC_RXDMA] && !(special && rxMode1))
                  rxDmaCnt_reg <= 2'(SCSB_DMA_PULSE_CYC);
               else if (rxDmaCnt_reg != 2'd0) rxDmaCnt_reg <= rxDmaCnt_reg - 2'd1;
            end
         end
         assign link.txDmaRequest_n[c] = txDmaCnt_reg == 2'd0;
         assign link.rxDmaRequest_n[c] = rxDmaCnt_reg == 2'd0;
         assign pendAll[3*c] = rxPend_reg | specPend_reg;
         assign pendAll[3*c+1] = txPend_reg;
         assign pendAll[3*c+2] = extPend_reg;
         assign ackSeq[c] = specPend_reg;
      end
   endgenerate
   // ******************************************************
   // Priority and vector
   // ******************************************************
   // Fixed priority: lowest index wins
   always_comb begin
      winner = 3'd7;
      for (int i = 5; i >= 0; i--) begin
         if (pendAll[i]) winner = {i >= 3 ? 1'b1 : 1'b0, 2'(i % 3)};
      end
   end
   assign anyPend = |pendAll;
   assign link.intReq_n = ~anyPend;
   logic [2:0] vecCode;
   // Eight routines: channel, source, special receive
   assign vecCode = winner[1:0] == 2'd0 && ackSeq[winner[2]] ? {winner[2], 2'b11}
      : {winner[2], winner[1:0] == 2'd0 ? 2'b10 : (winner[1:0] == 2'd1 ? 2'b00 : 2'b01)};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) vect_reg <= SCSB_VECT_RESET;
      else if (link.wr && link.addr == SCSB_REG_VECT) vect_reg <= link.wdata[7:0];
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) link.rdata <= '0;
      else if (link.rd) begin
         if (link.addr == SCSB_REG_ACK || link.addr == SCSB_REG_VECT)
            link.rdata <= {8'h00, globalSav && anyPend ? {vect_reg[7:3], vecCode} : vect_reg};
         else if (link.addr[4:3] < 2'd2 && link.addr[2:0] == SCSB_REG_STAT0[2:0])
            link.rdata <= {8'h00, chRd[link.addr[3]][7:0]};
         else if (link.addr[4:3] < 2'd2 && link.addr[2:0] == SCSB_REG_STAT1[2:0])
            link.rdata <= {8'h00, 4'h0, 4'h0};
         else if (link.addr[4:3] < 2'd2 && link.addr[2:0] == SCSB_REG_DATA[2:0])
            link.rdata <= {8'h00, chRd[link.addr[3]][15:8]};
         else if (link.addr[4:3] < 2'd2 && link.addr[2:0] == SCSB_REG_CTRL[2:0])
            link.rdata <= {7'h00, ctrl[link.addr[3]]};
         else link.rdata <= 16'hFFFF;
      end
   end
endmodule // scsb_device
`default_nettype wire

// ==== dv/scsb_link_chk.sv ====
// Checker: properties of the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module scsb_link_chk
   import scsb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic intReq_n,
   input wire logic [1:0] txDmaRequest_n,
   input wire logic [1:0] rxDmaRequest_n
);
   // ****
   // Shadow of both control registers
   // ****
   logic [15:0] ctrlA_reg, ctrlB_reg;
   wire logic irqOff = (ctrlA_reg[3:0] == 4'h0) && (ctrlB_reg[3:0] == 4'h0);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrlA_reg <= 16'h0000;
         ctrlB_reg <= 16'h0000;
      end else if (wr && addr == SCSB_REG_CTRL) begin
         ctrlA_reg <= wdata;
      end else if (wr && addr == SCSB_REG_CTRL + SCSB_CH_STRIDE) begin
         ctrlB_reg <= wdata;
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   property p_txDmaA;
      $fell(txDmaRequest_n[0]) |-> ##1 !txDmaRequest_n[0] [*2] ##1 txDmaRequest_n[0];
   endproperty
   a_txDmaA: assert property (p_txDmaA) else $error("tx request A width");
   property p_txDmaB;
      $fell(txDmaRequest_n[1]) |-> !txDmaRequest_n[1] [*3] ##1 txDmaRequest_n[1];
   endproperty
   a_txDmaB: assert property (p_txDmaB) else $error("tx request B width");
   property p_rxDmaA;
      $fell(rxDmaRequest_n[0]) |-> !rxDmaRequest_n[0] [*3] ##1 rxDmaRequest_n[0];
   endproperty
   a_rxDmaA: assert property (p_rxDmaA) else $error("rx request A width");
   property p_rxDmaB;
      $fell(rxDmaRequest_n[1]) |-> ##2 $past(!rxDmaRequest_n[1], 2) && !rxDmaRequest_n[1] ##1 rxDmaRequest_n[1];
   endproperty
   a_rxDmaB: assert property (p_rxDmaB) else $error("rx request B width");
   property p_polled; irqOff [*3] |-> intReq_n; endproperty
   a_polled: assert property (p_polled) else $error("interrupt while all disabled");
   property p_rxDmaOffA;
      (!ctrlA_reg[SCSB_IC_RXDMA]) [*4] |-> rxDmaRequest_n[0];
   endproperty
   a_rxDmaOffA: assert property (p_rxDmaOffA) else $error("rx request A disabled");
   property p_txDmaOffB;
      (!ctrlB_reg[SCSB_IC_TXDMA]) [*4] |-> txDmaRequest_n[1];
   endproperty
   a_txDmaOffB: assert property (p_txDmaOffB) else $error("tx request B disabled");
   property p_resetIdle;
      $fell(rst) |-> intReq_n && (&txDmaRequest_n) && (&rxDmaRequest_n);
   endproperty
   a_resetIdle: assert property (p_resetIdle) else $error("outputs busy after reset");
   property p_unmapped; rd && addr == 5'h07 |=> rdata == 16'hFFFF; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read value");
   c_irq: cover property ($fell(intReq_n));
   c_txDmaB: cover property ($fell(txDmaRequest_n[1]));
   c_rxDmaA: cover property ($fell(rxDmaRequest_n[0]));
endmodule // scsb_link_chk
`default_nettype wire

// ==== dv/serial_channel_service_and_baud_gen_bench.sv ====
// Testbench: host and device ends joined over the link interface
`timescale 1ns/1ps
`default_nettype none
module serial_channel_service_and_baud_gen_bench;
   import scsb_pkg::*;
   // ****
   // Stimulus, observation and the two ends
   // ****
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] userAddr = 5'h00;
   logic [15:0] userWdata = 16'h0000;
   logic userWr = 1'b0;
   logic userRd = 1'b0;
   logic [1:0] rxCharStb = 2'h0, rxParErr = 2'h0, rxFrameErr = 2'h0, rxEndFrame = 2'h0;
   logic [1:0] txLoadStb = 2'h0, txUnderrun = 2'h0, breakDet = 2'h0, ctsPin = 2'h0;
   logic [1:0] dcdPin = 2'h0, syncPin = 2'h0, txDataLine = 2'h0, rxDataPin = 2'h0;
   logic [1:0] txClkDrv = 2'h0, rxClkDrv = 2'h0;
   logic [15:0] rxCharData = 16'h0000;
   logic [15:0] userRdata;
   logic userRdValid, intPending;
   logic [1:0] txDmaSeen, rxDmaSeen, txClockPinOut, txClockPinOe_n, rxClockPinOut;
   logic [1:0] rxClockPinOe_n, rxDataInternal, rxClockInternal;
   int mismatches = 0;
   int comparisons = 0;
   // Shared clock pins: the device wins wherever its enable is low
   wire logic [1:0] txClkWire = (~txClockPinOe_n & txClockPinOut) | (txClockPinOe_n & txClkDrv);
   wire logic [1:0] rxClkWire = (~rxClockPinOe_n & rxClockPinOut) | (rxClockPinOe_n & rxClkDrv);
   scsb_link_if link();
   scsb_host scsb_host_inst (.*);
   scsb_device scsb_device_inst (.*, .txClockPinIn(txClkWire), .rxClockPinIn(rxClkWire));
   scsb_link_chk scsb_link_chk_inst (.ref_clk(ref_clk), .rst(rst), .addr(link.addr),
      .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
      .intReq_n(link.intReq_n), .txDmaRequest_n(link.txDmaRequest_n),
      .rxDmaRequest_n(link.rxDmaRequest_n));
   // ****
   // Shared tasks
   // ****
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic busWrite(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      userAddr <= a;
      userWdata <= d;
      userWr <= 1'b1;
      @(posedge ref_clk);
      userWr <= 1'b0;
   endtask
   task automatic expRead(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge ref_clk);
      userAddr <= a;
      userRd <= 1'b1;
      @(posedge ref_clk);
      userRd <= 1'b0;
      @(negedge ref_clk);
      check(link.rdata & m, e);
   endtask
   task automatic cmd(input logic [2:0] c);
      busWrite(SCSB_REG_CMD, {13'h0000, c});
   endtask
   task automatic expAck(input logic [2:0] e);
      expRead(SCSB_REG_ACK, 16'h0007, {13'h0000, e});
   endtask
   task automatic rxA(input logic [7:0] e);
      expRead(SCSB_REG_DATA, 16'h00FF, {8'h00, e});
   endtask
   task automatic rxChar(input int ch, input logic [7:0] d, input logic fe);
      @(posedge ref_clk);
      rxCharStb[ch] <= 1'b1;
      rxCharData[ch*8 +: 8] <= d;
      rxFrameErr[ch] <= fe;
      @(posedge ref_clk);
      rxCharStb[ch] <= 1'b0;
      rxFrameErr[ch] <= 1'b0;
   endtask
   task automatic txLoad(input int ch);
      @(posedge ref_clk);
      txLoadStb[ch] <= 1'b1;
      @(posedge ref_clk);
      txLoadStb[ch] <= 1'b0;
   endtask
   task automatic countLow(input int ch, input int tx, output int n);
      n = 0;
      repeat (12) begin
         @(negedge ref_clk);
         if ((tx != 0 ? txDmaSeen[ch] : rxDmaSeen[ch]) === 1'b1) n++;
      end
   endtask
   task automatic waitIrq();
      int i;
      for (i = 0; i < 40 && intPending !== 1'b1; i++) @(posedge ref_clk);
      if (intPending !== 1'b1) begin
         check({15'h0000, intPending}, 16'h0001);
         give_verdict();
      end
   endtask
   task automatic idleCheck();
      repeat (10) @(posedge ref_clk);
      check({15'h0000, intPending}, 16'h0000);
   endtask
   task automatic waitRise(output int n);
      logic last;
      n = 0;
      last = 1'b1;
      while (n < 2000 && !(last === 1'b0 && txClockPinOut[0] === 1'b1)) begin
         last = txClockPinOut[0];
         @(negedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         check(16'h0000, 16'h0001);
         give_verdict();
      end
   endtask
   // ****
   // Scenarios
   // ****
   task automatic scReset();
      check({12'h000, txClockPinOe_n, rxClockPinOe_n}, 16'h000F);
      check({12'h000, txDmaSeen, rxDmaSeen}, 16'h0000);
      expRead(5'h07, 16'hFFFF, 16'hFFFF);
   endtask
   task automatic scPoll();
      busWrite(SCSB_REG_CTRL, 16'h0000);
      rxChar(0, 8'hA5, 1'b0);
      rxChar(0, 8'h5A, 1'b0);
      rxChar(0, 8'h3C, 1'b0);
      expRead(SCSB_REG_STAT0, 16'h0001, 16'h0001);
      check(16'(intPending), 16'h0000);
      rxA(8'hA5);
      rxA(8'h5A);
      rxA(8'h3C);
      expRead(SCSB_REG_STAT0, 16'h0001, 16'h0000);
      txLoad(0);
      expRead(SCSB_REG_STAT0, 16'h0004, 16'h0004);
   endtask
   task automatic scDma();
      int n;
      busWrite(SCSB_REG_CTRL, 16'h00C0);
      busWrite(SCSB_REG_CTRL + SCSB_CH_STRIDE, 16'h00C0);
      for (int c = 0; c < 2; c++) begin
         rxChar(c, 8'h40, 1'b0);
         countLow(c, 0, n);
         check(16'(n), 16'h0003);
         txLoad(c);
         countLow(c, 1, n);
         check(16'(n), 16'h0003);
      end
      rxA(8'h40);
      expRead(SCSB_REG_DATA + SCSB_CH_STRIDE, 16'h00FF, 16'h0040);
   endtask
   task automatic scPriority();
      busWrite(SCSB_REG_CTRL, 16'h0001);
      busWrite(SCSB_REG_CTRL + SCSB_CH_STRIDE, 16'h001C);
      rxChar(1, 8'h11, 1'b0);
      txLoad(0);
      waitIrq();
      expAck(3'h0);
      expAck(3'h6);
      expRead(SCSB_REG_DATA + SCSB_CH_STRIDE, 16'h00FF, 16'h0011);
      idleCheck();
      busWrite(SCSB_REG_CTRL + SCSB_CH_STRIDE, 16'h0010);
   endtask
   task automatic scFirstChar();
      int n;
      busWrite(SCSB_REG_CTRL, 16'h0014);
      rxChar(0, 8'h21, 1'b0);
      waitIrq();
      expAck(3'h2);
      rxA(8'h21);
      rxChar(0, 8'h22, 1'b0);
      idleCheck();
      cmd(SCSB_CMD_NEXT_RX);
      rxChar(0, 8'h23, 1'b0);
      waitIrq();
      expAck(3'h2);
      rxA(8'h22);
      rxA(8'h23);
      busWrite(SCSB_REG_CTRL, 16'h0094);
      rxChar(0, 8'h24, 1'b1);
      countLow(0, 0, n);
      check(16'(n), 16'h0000);
      check(16'(intPending), 16'h0001);
      expAck(3'h3);
      cmd(SCSB_CMD_ERR_RST);
      rxA(8'h24);
      busWrite(SCSB_REG_CTRL, 16'h0000);
   endtask
   task automatic scExt();
      busWrite(SCSB_REG_CTRL, 16'h0002);
      cmd(SCSB_CMD_RST_EXT);
      ctsPin[0] <= 1'b1;
      waitIrq();
      expAck(3'h1);
      breakDet[0] <= 1'b1;
      idleCheck();
      cmd(SCSB_CMD_RST_EXT);
      breakDet[0] <= 1'b0;
      waitIrq();
      expAck(3'h1);
      cmd(SCSB_CMD_RST_EXT);
      busWrite(SCSB_REG_CTRL, 16'h0000);
   endtask
   task automatic scLoop();
      busWrite(SCSB_REG_CTRL, 16'h0100);
      txDataLine <= 2'b01;
      rxDataPin <= 2'b10;
      txClkDrv <= 2'b01;
      @(negedge ref_clk);
      check({12'h000, rxDataInternal, rxClockInternal}, 16'h000D);
      busWrite(SCSB_REG_CTRL, 16'h0000);
      @(negedge ref_clk);
      check({12'h000, rxDataInternal, rxClockInternal}, 16'h0008);
   endtask
   task automatic scBaud();
      logic [7:0] tcs [4] = '{8'h01, 8'h02, 8'h00, 8'h01};
      int per [4] = '{4, 8, 1024, 64};
      int i;
      int n;
      for (i = 0; i < 4; i++) begin
         busWrite(SCSB_REG_BRG, 16'h0000);
         busWrite(SCSB_REG_TC, {8'h00, tcs[i]});
         busWrite(SCSB_REG_BRG, {12'h000, 2'b01, 1'(i == 3), 1'b1});
         waitRise(n);
         waitRise(n);
         check(16'(n), 16'(per[i]));
      end
      check({12'h000, txClockPinOe_n, rxClockPinOe_n}, 16'h000B);
      busWrite(SCSB_REG_BRG, 16'h0009);
      @(negedge ref_clk);
      check({12'h000, txClockPinOe_n, rxClockPinOe_n}, 16'h000E);
      busWrite(SCSB_REG_BRG, 16'h0000);
   endtask
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      scReset();
      scPoll();
      scDma();
      scPriority();
      scFirstChar();
      scExt();
      scLoop();
      scBaud();
      give_verdict();
   end
endmodule // serial_channel_service_and_baud_gen_bench
`default_nettype wire
